/* File: verilog/fan_monitor_map.vh */
/*
  Register offsets, reset values, field positions and mode codes of the
  fan monitor configuration block.
  Assumes inclusion by bare name from each design file that needs it.
*/
`ifndef FAN_MONITOR_MAP_VH
`define FAN_MONITOR_MAP_VH

`define FMC_CFG1_ADDR      8'h00
`define FMC_CFG2_ADDR      8'h01
`define FMC_CFG1_RESET     8'hD4
`define FMC_CFG2_RESET     8'h3D

`define FMC_OVERTEMP_OUTPUT_IE_BIT   7
`define FMC_DRV_HI_BIT     6
`define FMC_DRV_LO_BIT     5
`define FMC_FAULT_EN_BIT   4
`define FMC_PWM_INV_BIT    3
`define FMC_FAN_IE_BIT     2
`define FMC_ALERT_EN_BIT   1
`define FMC_START_BIT      0
`define FMC_SWRST_BIT      7

`define FMC_MODE_MAX       2'h3
`define FMC_MODE_REMOTE    2'h2
`define FMC_MODE_SW_DUTY   2'h0
`define FMC_MODE_SW_RPM    2'h1

`define FMC_SLAVE_ADDR     7'h18
`define FMC_LOOP_DIV       1000
`define FMC_PWM_PRESCALE   4

`endif

/* File: verilog/bit_sync2.v */
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence across bits.
*/
`timescale 1ns/100ps

module bit_sync2 #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // idle bus level is high, so reset to ones
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_reg <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule // bit_sync2

/* File: verilog/pwm_wave_gen.v */
/*
  PWM waveform generator with polarity control for the fan drive pin.
  Assumes duty 8'hFF means 100%; pin is open drain when inverted.
*/
`timescale 1ns/100ps

module pwm_wave_gen #(
  parameter PRESCALE = 4
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       soft_rst,
  input  wire [7:0] duty,
  input  wire       invert,
  output reg        pin_out,
  output reg        pin_oe
);

  reg  [15:0] pre_reg;
  reg  [7:0]  cnt_reg;
  wire        tick;
  wire        active;

  assign tick   = (pre_reg == PRESCALE[15:0] - 16'h0001);
  // period of 255 steps so that 8'hFF stays active all the time
  assign active = (cnt_reg < duty);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 16'h0000;
      cnt_reg <= 8'h00;
      pin_out <= 1'b1;
      pin_oe  <= 1'b0;
    end else if (soft_rst) begin
      pre_reg <= 16'h0000;
      cnt_reg <= 8'h00;
      pin_out <= 1'b1;
      pin_oe  <= 1'b0;
    end else begin
      pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
      if (tick) begin
        cnt_reg <= (cnt_reg == 8'hFE) ? 8'h00 : cnt_reg + 8'h01;
      end
      if (invert) begin
        pin_out <= 1'b0;
        pin_oe  <= ~active;
      end else begin
        pin_out <= ~active;
        pin_oe  <= 1'b1;
      end
    end
  end

endmodule // pwm_wave_gen

/* File: verilog/fan_monitor_config_regs.v */
/*
  Configuration registers of a temperature monitor and PWM fan controller,
  reached over an SMBus slave, with alert, overtemp, fault and PWM pins.
  Assumes flags, duty values and speed counts come from logic on MCLK;
  SCL and SDA arrive asynchronously from the bus.
*/
`timescale 1ns/100ps
`include "fan_monitor_map.vh"

module fan_monitor_config_regs #(
  parameter [6:0] SLAVE_ADDR   = `FMC_SLAVE_ADDR,
  parameter       LOOP_DIV     = `FMC_LOOP_DIV,
  parameter       PWM_PRESCALE = `FMC_PWM_PRESCALE
) (
  input  wire        MCLK,
  input  wire        RST,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  input  wire        LOCAL_OVERTEMP_FLAG,
  input  wire        REMOTE_OVERTEMP_FLAG,
  input  wire        FAN_STALL_FLAG,
  input  wire        SPEED_ALARM_FLAG,
  input  wire [7:0]  DUTY_CYCLE_SETTING,
  input  wire [15:0] SPEED_TARGET,
  input  wire [15:0] SPEED_MEASURED,
  input  wire [7:0]  REMOTE_DUTY,
  input  wire [7:0]  LOCAL_DUTY,
  output wire        ALERT_N_OUT,
  output wire        ALERT_N_OE,
  output wire        OVERTEMP_OUTPUT_OUT,
  output wire        OVERTEMP_OUTPUT_OE,
  output wire        FAN_FAULT_OUT,
  output wire        FAN_FAULT_OE,
  output wire        PWM_OUT,
  output wire        PWM_OE,
  output wire [7:0]  DUTY_ACTIVE,
  output wire [7:0]  CONFIG_PRIMARY,
  output wire [7:0]  CONFIG_SECONDARY,
  output wire        SOFT_RESET
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RX   = 3'h1;
  localparam [2:0] S_ACKW = 3'h2;
  localparam [2:0] S_ACKH = 3'h3;
  localparam [2:0] S_TX   = 3'h4;
  localparam [2:0] S_TXR  = 3'h5;
  localparam [2:0] S_MACK = 3'h6;
  localparam [7:0] CFG2_INIT = `FMC_CFG2_RESET;
  reg  [7:0]  cfg1_reg, shift_reg, ptr_reg;
  reg  [7:0]  duty_active_reg, loop_duty_reg;
  reg  [6:0]  cfg2_reg;
  reg  [2:0]  st_reg, bit_cnt_reg;
  reg  [1:0]  byte_idx_reg;
  reg  [15:0] loop_cnt_reg;
  reg         rw_reg, sda_drv_reg, sw_rst_reg, scl_d_reg, sda_d_reg;
  reg         alert_reg, overtemp_reg, fault_reg;
  wire [1:0]  bus_s, mode;
  wire [7:0]  rx_byte, rd_data;
  wire        scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
  wire        loop_tick, any_overtemp_output, fan_bad, overtemp_output_int, fan_int;
  function [7:0] reg_read;
    input [7:0] addr;
    input [7:0] c1;
    input [6:0] c2;
    begin
      if (addr == `FMC_CFG1_ADDR) begin
        reg_read = c1;
      end else if (addr == `FMC_CFG2_ADDR) begin
        reg_read = {1'b0, c2};
      end else begin
        reg_read = 8'h00;
      end
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // bus pin sampling
  bit_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk  (MCLK),
    .rst  (RST),
    .din  ({SCL_IN, SDA_IN}),
    .dout (bus_s)
  );
  assign scl_s      = bus_s[1];
  assign sda_s      = bus_s[0];
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign rx_byte    = {shift_reg[6:0], sda_s};
  assign rd_data    = reg_read(ptr_reg, cfg1_reg, cfg2_reg);

  ////////////////////////////////////////////////////////////////////////////
  // slave sequencer and configuration registers
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg1_reg     <= `FMC_CFG1_RESET;
      cfg2_reg     <= CFG2_INIT[6:0];
      st_reg       <= S_IDLE;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 2'h0;
      shift_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      rw_reg       <= 1'b0;
      sda_drv_reg  <= 1'b0;
      sw_rst_reg   <= 1'b0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_d_reg  <= scl_s;
      sda_d_reg  <= sda_s;
      sw_rst_reg <= 1'b0;
      if (start_cond) begin
        st_reg       <= S_RX;
        bit_cnt_reg  <= 3'h0;
        byte_idx_reg <= 2'h0;
        sda_drv_reg  <= 1'b0;
      end else if (stop_cond) begin
        st_reg      <= S_IDLE;
        sda_drv_reg <= 1'b0;
      end else begin
        case (st_reg)
          S_RX: begin
            if (scl_rise) begin
              shift_reg   <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                st_reg <= S_ACKW;
                if (byte_idx_reg != 2'h2) begin
                  byte_idx_reg <= byte_idx_reg + 2'h1;
                end
                if (byte_idx_reg == 2'h0) begin
                  rw_reg <= rx_byte[0];
                  if (rx_byte[7:1] != SLAVE_ADDR) begin
                    st_reg <= S_IDLE;
                  end
                end else if (byte_idx_reg == 2'h1) begin
                  ptr_reg <= rx_byte;
                end else if (ptr_reg == `FMC_CFG2_ADDR && rx_byte[`FMC_SWRST_BIT]) begin
                  cfg1_reg   <= `FMC_CFG1_RESET;
                  cfg2_reg   <= CFG2_INIT[6:0];
                  sw_rst_reg <= 1'b1;
                  ptr_reg    <= 8'h00;
                  // acts on LSB rise, no ack
                  st_reg     <= S_IDLE;
                end else begin
                  if (ptr_reg == `FMC_CFG1_ADDR) begin
                    cfg1_reg <= rx_byte;
                  end else if (ptr_reg == `FMC_CFG2_ADDR) begin
                    cfg2_reg <= rx_byte[6:0];
                  end
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          S_ACKW: begin
            if (scl_fall) begin
              sda_drv_reg <= 1'b1;
              st_reg      <= S_ACKH;
            end
          end
          S_ACKH: begin
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (rw_reg) begin
                shift_reg   <= rd_data;
                sda_drv_reg <= ~rd_data[7];
                ptr_reg     <= ptr_reg + 8'h01;
                st_reg      <= S_TX;
              end else begin
                sda_drv_reg <= 1'b0;
                st_reg      <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                st_reg <= S_TXR;
              end
            end else if (scl_fall) begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_drv_reg <= ~shift_reg[6];
            end
          end
          S_TXR: begin
            if (scl_fall) begin
              sda_drv_reg <= 1'b0;
              st_reg      <= S_MACK;
            end
          end
          S_MACK: begin
            // master nack ends the read
            if (scl_rise) begin
              st_reg <= sda_s ? S_IDLE : S_ACKH;
            end
          end
          default: begin
            sda_drv_reg <= 1'b0;
            st_reg      <= S_IDLE;
          end
        endcase
      end
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_drv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // fan drive selection and speed loop
  // select bits 6 and 5
  assign mode = cfg1_reg[`FMC_START_BIT] ?
                {cfg1_reg[`FMC_DRV_HI_BIT], cfg1_reg[`FMC_DRV_LO_BIT]} :
                `FMC_MODE_SW_DUTY;
  assign loop_tick = (loop_cnt_reg == LOOP_DIV[15:0] - 16'h0001);
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      loop_cnt_reg    <= 16'h0000;
      loop_duty_reg   <= 8'h00;
      duty_active_reg <= 8'h00;
    end else if (sw_rst_reg) begin
      loop_cnt_reg    <= 16'h0000;
      loop_duty_reg   <= 8'h00;
      duty_active_reg <= 8'h00;
    end else begin
      loop_cnt_reg <= loop_tick ? 16'h0000 : loop_cnt_reg + 16'h0001;
      // speed count above target means too slow
      if (loop_tick && mode == `FMC_MODE_SW_RPM) begin
        if (SPEED_MEASURED > SPEED_TARGET && loop_duty_reg != 8'hFF) begin
          loop_duty_reg <= loop_duty_reg + 8'h01;
        end else if (SPEED_MEASURED < SPEED_TARGET && loop_duty_reg != 8'h00) begin
          loop_duty_reg <= loop_duty_reg - 8'h01;
        end
      end
      case (mode)
        `FMC_MODE_MAX: begin
          duty_active_reg <= (REMOTE_DUTY > LOCAL_DUTY) ? REMOTE_DUTY : LOCAL_DUTY;
        end
        `FMC_MODE_REMOTE: begin
          duty_active_reg <= REMOTE_DUTY;
        end
        `FMC_MODE_SW_RPM: begin
          duty_active_reg <= loop_duty_reg;
        end
        default: begin
          duty_active_reg <= DUTY_CYCLE_SETTING;
        end
      endcase
    end
  end

  pwm_wave_gen #(
    .PRESCALE (PWM_PRESCALE)
  ) u_pwm (
    .clk      (MCLK),
    .rst      (RST),
    .soft_rst (sw_rst_reg),
    .duty     (duty_active_reg),
    .invert   (cfg1_reg[`FMC_PWM_INV_BIT]),
    .pin_out  (PWM_OUT),
    .pin_oe   (PWM_OE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and status pins
  assign any_overtemp_output = LOCAL_OVERTEMP_FLAG | REMOTE_OVERTEMP_FLAG;
  assign fan_bad   = FAN_STALL_FLAG | SPEED_ALARM_FLAG;
  assign overtemp_output_int = cfg1_reg[`FMC_OVERTEMP_OUTPUT_IE_BIT] & any_overtemp_output;
  assign fan_int   = cfg1_reg[`FMC_FAN_IE_BIT] & fan_bad;
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      alert_reg    <= 1'b0;
      overtemp_reg <= 1'b0;
      fault_reg    <= 1'b0;
    end else begin
      alert_reg    <= cfg1_reg[`FMC_ALERT_EN_BIT] & (overtemp_output_int | fan_int);
      overtemp_reg <= ~cfg1_reg[`FMC_OVERTEMP_OUTPUT_IE_BIT] & any_overtemp_output;
      fault_reg    <= cfg1_reg[`FMC_FAULT_EN_BIT] & fan_bad;
    end
  end
  // open-drain pins only ever pull low
  assign ALERT_N_OUT         = 1'b0;
  assign ALERT_N_OE          = alert_reg;
  assign OVERTEMP_OUTPUT_OUT = 1'b0;
  assign OVERTEMP_OUTPUT_OE  = overtemp_reg;
  assign FAN_FAULT_OUT       = 1'b0;
  assign FAN_FAULT_OE        = fault_reg;
  assign DUTY_ACTIVE         = duty_active_reg;
  assign CONFIG_PRIMARY      = cfg1_reg;
  assign CONFIG_SECONDARY    = {1'b0, cfg2_reg};
  assign SOFT_RESET          = sw_rst_reg;

endmodule // fan_monitor_config_regs

/* File: tb/smbus_host_model.sv */
/*
  Behavioural SMBus host: start, stop, byte send and receive.
  Assumes SDA is wired open drain with a pull-up in the bench.
*/
`timescale 1ns/100ps

module smbus_host_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 12;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // also serves as repeated start from a low clock
  task automatic start();
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(4);
  endtask

  // data held a few cycles past the clock fall, as synchronisers lag
  task automatic xfer(input logic b, output logic r);
    sda_low = !b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sda;
    scl = 1'b0;
    tick(4);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = !r;
  endtask

  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(1'b1, r);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
endmodule // smbus_host_model

/* File: tb/fan_monitor_config_regs_sva.sv */
/*
  Port checker for the fan monitor configuration block.
  Assumes one clock, MCLK, and asynchronous reset RST.
*/
`timescale 1ns/100ps

module fan_monitor_config_regs_sva (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       LOCAL_OVERTEMP_FLAG,
  input wire logic       REMOTE_OVERTEMP_FLAG,
  input wire logic       FAN_STALL_FLAG,
  input wire logic       SPEED_ALARM_FLAG,
  input wire logic [7:0] DUTY_CYCLE_SETTING,
  input wire logic [7:0] REMOTE_DUTY,
  input wire logic [7:0] LOCAL_DUTY,
  input wire logic       ALERT_N_OE,
  input wire logic       OVERTEMP_OUTPUT_OE,
  input wire logic       FAN_FAULT_OE,
  input wire logic       PWM_OUT,
  input wire logic       PWM_OE,
  input wire logic [7:0] DUTY_ACTIVE,
  input wire logic [7:0] CONFIG_PRIMARY,
  input wire logic [7:0] CONFIG_SECONDARY,
  input wire logic       SOFT_RESET
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire       th = LOCAL_OVERTEMP_FLAG | REMOTE_OVERTEMP_FLAG;
  wire       fn = FAN_STALL_FLAG | SPEED_ALARM_FLAG;
  wire [7:0] c = CONFIG_PRIMARY;
  wire [7:0] mx = (REMOTE_DUTY > LOCAL_DUTY) ? REMOTE_DUTY : LOCAL_DUTY;
  ////////////////////////////////////////////////////////////////
  alert_gate_a: assert property (
    ALERT_N_OE == $past(c[1] && (c[7] && th || c[2] && fn)))
    else $error("alert pin wrong");
  overtemp_pin_a: assert property (
    OVERTEMP_OUTPUT_OE == $past(!c[7] && th)) else $error("overtemp pin wrong");
  fault_pin_a: assert property (
    FAN_FAULT_OE == $past(c[4] && fn)) else $error("fault pin wrong");
  swrst_zero_a: assert property (
    CONFIG_SECONDARY[7] == 1'b0) else $error("reset bit reads one");
  swrst_defaults_a: assert property (
    SOFT_RESET |-> c == 8'hD4 && CONFIG_SECONDARY == 8'h3D)
    else $error("soft reset left registers");
  sw_duty_a: assert property (
    !c[0] |=> DUTY_ACTIVE == $past(DUTY_CYCLE_SETTING)) else $error("sw duty wrong");
  max_duty_a: assert property (
    c[0] && c[6:5] == 2'h3 |=> DUTY_ACTIVE == $past(mx)) else $error("max duty wrong");
  remote_duty_a: assert property (
    c[0] && c[6:5] == 2'h2 |=> DUTY_ACTIVE == $past(REMOTE_DUTY))
    else $error("remote duty wrong");
  pwm_low_a: assert property (
    (!c[3] && DUTY_ACTIVE == 8'hFF) [*4] |=> PWM_OE && !PWM_OUT)
    else $error("pwm not low at full duty");
  pwm_release_a: assert property (
    (c[3] && DUTY_ACTIVE == 8'hFF) [*4] |=> !PWM_OE) else $error("pwm not released");
  cover property (SOFT_RESET);
  cover property (ALERT_N_OE);
  cover property (c[0] && c[6:5] == 2'h3);
endmodule // fan_monitor_config_regs_sva

bind fan_monitor_config_regs fan_monitor_config_regs_sva i_sva (.*);

/* File: tb/fan_monitor_config_regs_test.sv */
/*
  Self-checking bench for the configuration block, driven over SMBus.
  Assumes the host model and plain level flags on the far side.
*/
`timescale 1ns/100ps

module fan_monitor_config_regs_test;
  localparam logic [6:0] DEV = 7'h18;
  logic        mclk, rst, scl, sda_low, sda, lot, rot, stall, alarm, ack;
  logic        sda_oe, alert_oe, ot_oe, flt_oe, pwm_out, pwm_oe, soft_rst, soft_seen;
  logic [7:0]  duty_set, rduty, lduty, duty_act, cfg1, cfg2, d, c;
  logic [15:0] tgt, meas;
  logic [3:0]  lows;
  int          mismatches = 0;
  int          n_tests = 0;
  logic [7:0]  irqc [4] = '{8'hD6, 8'h12, 8'h84, 8'h26};
  logic [15:0] modes [6] = '{16'h6190, 16'h4140, 16'h0120, 16'h6020, 16'h4020, 16'h2020};
  logic [17:0] pw [4] = '{18'h003FE, 18'h023FC, 18'h00003, 18'h02002};

  assign sda = !(sda_low || sda_oe);

  fan_monitor_config_regs #(.SLAVE_ADDR(DEV), .LOOP_DIV(4), .PWM_PRESCALE(1)) i_dut (
    .MCLK(mclk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(lows[0]), .SDA_OE(sda_oe),
    .LOCAL_OVERTEMP_FLAG(lot), .REMOTE_OVERTEMP_FLAG(rot), .FAN_STALL_FLAG(stall),
    .SPEED_ALARM_FLAG(alarm), .DUTY_CYCLE_SETTING(duty_set), .SPEED_TARGET(tgt),
    .SPEED_MEASURED(meas), .REMOTE_DUTY(rduty), .LOCAL_DUTY(lduty),
    .ALERT_N_OUT(lows[1]), .ALERT_N_OE(alert_oe), .OVERTEMP_OUTPUT_OUT(lows[2]),
    .OVERTEMP_OUTPUT_OE(ot_oe), .FAN_FAULT_OUT(lows[3]), .FAN_FAULT_OE(flt_oe),
    .PWM_OUT(pwm_out), .PWM_OE(pwm_oe), .DUTY_ACTIVE(duty_act),
    .CONFIG_PRIMARY(cfg1), .CONFIG_SECONDARY(cfg2), .SOFT_RESET(soft_rst));

  smbus_host_model i_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = !mclk;
  end

  always @(posedge mclk) if (soft_rst === 1'b1) soft_seen <= 1'b1;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic a);
    logic a0;
    i_host.start();
    i_host.send({DEV, 1'b0}, a0);
    i_host.send(p, a0);
    i_host.send(v, a);
    i_host.stop();
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [7:0] v);
    logic a0;
    i_host.start();
    i_host.send({DEV, 1'b0}, a0);
    i_host.send(p, a0);
    i_host.start();
    i_host.send({DEV, 1'b1}, a0);
    i_host.recv(v);
    i_host.stop();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    soft_seen = 1'b0;
    {lot, rot, stall, alarm} = 4'h0;
    {duty_set, rduty, lduty} = 24'h0;
    {tgt, meas} = 32'h0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    read_reg(8'h00, d);
    check("cfg1 reset", 8'hD4, d);
    read_reg(8'h01, d);
    check("cfg2 reset", 8'h3D, d);
    read_reg(8'h3A, d);
    check("unmapped", 8'h00, d);
    foreach (irqc[i]) begin
      write_reg(8'h00, irqc[i], ack);
      c = irqc[i];
      for (int f = 0; f < 16; f++) begin
        {lot, rot, stall, alarm} = 4'(f);
        repeat (3) @(negedge mclk);
        d[0] = c[7] & (lot | rot) | c[2] & (stall | alarm);
        check("alert", c[1] & d[0], alert_oe);
        check("overtemp", !c[7] & (lot | rot), ot_oe);
        check("fault", c[4] & (stall | alarm), flt_oe);
        check("pins low", 4'h0, lows);
      end
    end
    {lot, rot, stall, alarm} = 4'h0;
    rduty = 8'h40;
    lduty = 8'h90;
    duty_set = 8'h20;
    foreach (modes[i]) begin
      write_reg(8'h00, modes[i][15:8], ack);
      repeat (3) @(negedge mclk);
      check("write ack", 1'b1, ack);
      check("cfg1 rw", modes[i][15:8], cfg1);
      check("duty", modes[i][7:0], duty_act);
    end
    meas = 16'h0200;
    tgt = 16'h0100;
    write_reg(8'h00, 8'h21, ack);
    d = duty_act;
    repeat (32) @(negedge mclk);
    check("loop up", 1'b1, 8'(duty_act - d) inside {[7:9]});
    meas = 16'h0080;
    d = duty_act;
    repeat (32) @(negedge mclk);
    check("loop down", 1'b1, 8'(d - duty_act) inside {[7:9]});
    foreach (pw[i]) begin
      duty_set = pw[i][9:2];
      write_reg(8'h00, pw[i][17:10], ack);
      repeat (8) @(negedge mclk);
      check("pwm pin", pw[i][1:0], {pwm_oe, pwm_out});
    end
    write_reg(8'h01, 8'h42, ack);
    repeat (3) @(negedge mclk);
    check("cfg2 rw", 8'h42, cfg2);
    read_reg(8'h01, d);
    check("cfg2 back", 8'h42, d);
    write_reg(8'h01, 8'h80, ack);
    check("swrst ack", 1'b0, ack);
    check("swrst cfg1", 8'hD4, cfg1);
    check("swrst pulse", 1'b1, soft_seen);
    read_reg(8'h01, d);
    check("cfg2 read", 8'h3D, d);
    report_and_stop();
  end
endmodule // fan_monitor_config_regs_test
